/* verilog/nad_pkg.sv */
`default_nettype none
package nad_pkg;

  // clock and check timer
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned CHK_TIME_MS = 1000;
  localparam int unsigned CHK_MIN_MS  = 900;
  localparam int unsigned CHK_MAX_MS  = 1500;
  localparam int unsigned CHK_CYC     = CHK_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W       = 26;

  // identifier and first data byte layout of a check message
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned ID_W      = 11;
  localparam int unsigned ADDR_LSB  = 3;
  localparam int unsigned RR_BIT    = 7;
  localparam logic [1:0]  GRP2_TAG  = 2'h2;
  localparam logic [2:0]  CHK_MSGID = 3'h7;

  // reset values
  localparam logic [ID_W-1:0] ID_RST = 11'h000;

  typedef enum logic [1:0] {ST_SEND, ST_WAIT, ST_ONLINE, ST_FAULT} nad_state_t;

  function automatic logic [ID_W-1:0] nad_chk_id(input logic [ADDR_W-1:0] addr);
    return {GRP2_TAG, addr, CHK_MSGID};
  endfunction

  function automatic logic nad_is_chk(input logic [ID_W-1:0] id);
    return (id[ID_W-1 -: 2] == GRP2_TAG) && (id[2:0] == CHK_MSGID);
  endfunction

endpackage
`default_nettype wire

/* verilog/nad_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module nad_timer
  import nad_pkg::*;
#(
  parameter logic [TMR_W-1:0] LOAD = TMR_W'(CHK_CYC)
)
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      expire_o
);

  logic [TMR_W-1:0] cnt_q;
  logic             run_q;
  logic             exp_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_q <= LOAD;
      run_q <= 1'b1;
    end
    else if (stop_i || (run_q && cnt_q <= TMR_W'(1)))
    begin
      run_q <= 1'b0;
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - TMR_W'(1);
    end
  end

  // a stop in the same cycle still suppresses the pulse
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      exp_q <= 1'b0;
    else
      exp_q <= run_q && !start_i && !stop_i && (cnt_q <= TMR_W'(1));
  end

  assign expire_o = exp_q;

endmodule
`default_nettype wire

/* verilog/nad_rx_class.sv */
`timescale 1ns/100ps
`default_nettype none
module nad_rx_class
  import nad_pkg::*;
(
  input  wire logic              rx_valid_i,
  input  wire logic [ID_W-1:0]   rx_id_i,
  input  wire logic [7:0]        rx_data0_i,
  input  wire logic [ADDR_W-1:0] node_address_i,
  output logic                   chk_req_o,
  output logic                   chk_rsp_o,
  output logic                   other_o
);

  logic is_chk;
  logic own;

  always_comb
  begin
    is_chk    = nad_is_chk(rx_id_i);                               // [R15]
    own       = (rx_id_i[ADDR_LSB +: ADDR_W] == node_address_i);   // [R16]
    chk_req_o = rx_valid_i && is_chk && own && !rx_data0_i[RR_BIT];
    chk_rsp_o = rx_valid_i && is_chk && own && rx_data0_i[RR_BIT];
    // check traffic for other nodes is neither ours nor an ordinary message
    other_o   = rx_valid_i && !is_chk;
  end

endmodule
`default_nettype wire

/* verilog/nad_top.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: after reset enter sending state and request a check request with own address
// R2: sent check request starts about one second timer, then waiting state
// R3: first timer expiry in waiting resends the request, back to sending
// R4: second consecutive expiry in waiting moves to on-line
// R5: bus-off while sending or waiting holds transceiver in reset, fault state
// R6: bus-off on-line with hold action holds transceiver in reset, fault state
// R7: bus-off on-line with auto action first resets the controller only, the transceiver is not reset
// R8: after that auto reset request a new check request, back to sending
// R9: on-line, a check request for our address is answered with a response
// R10: duplicate found on request in sending/waiting or response in sending/waiting/on-line
// R11: ordinary messages pass only on-line; fault state discards check traffic too
// R12: internal transmit passes only on-line, otherwise internal error pulse
// R13: error warning and error passive never affect the state machine
// R14: a lone node reaching error passive stays in its current state
// R15: check messages use group-2 form, address middle, type bits all one
// R16: outside the fault state, a check message carrying our own address is accepted and processed
module nad_top
  import nad_pkg::*;
#(
  parameter int unsigned CHECK_CYCLES = CHK_CYC
)
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] node_address_i,
  input  wire logic              bus_off_action_attr_i,
  input  wire logic              bus_off_i,
  input  wire logic              tx_done_i,
  input  wire logic              rx_valid_i,
  input  wire logic [ID_W-1:0]   rx_id_i,
  input  wire logic [7:0]        rx_data0_i,
  input  wire logic              int_tx_req_i,
  output logic                   chk_tx_req_o,
  output logic                   chk_tx_rsp_o,
  output logic [ID_W-1:0]        chk_tx_id_o,
  output logic                   xcvr_reset_o,
  output logic                   ctrl_reset_o,
  output logic                   dup_detect_o,
  output logic                   rx_accept_o,
  output logic                   int_tx_go_o,
  output logic                   int_err_o,
  output logic [1:0]             state_o
);

  nad_state_t      state_q;
  logic            boff_prev_q;
  logic            tmo_seen_q;
  logic            pend_q;
  logic            req_q;
  logic            rsp_q;
  logic [ID_W-1:0] id_q;
  logic            xcvr_q;
  logic            ctrl_q;
  logic            dup_q;
  logic            acc_q;
  logic            go_q;
  logic            err_q;

  logic rx_req;
  logic rx_rsp;
  logic rx_other;
  logic tmr_exp;
  logic boff_ev;
  logic in_pre;
  logic in_on;
  logic ev_dup;
  logic ev_boff_hold;
  logic ev_auto;
  logic ev_sent;
  logic ev_retry;
  logic ev_online;
  logic ev_resp;

  nad_rx_class u_class (
    .rx_valid_i     (rx_valid_i),
    .rx_id_i        (rx_id_i),
    .rx_data0_i     (rx_data0_i),
    .node_address_i (node_address_i),
    .chk_req_o      (rx_req),
    .chk_rsp_o      (rx_rsp),
    .other_o        (rx_other)
  );

  nad_timer #(
    .LOAD (TMR_W'(CHECK_CYCLES))
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (ev_sent),
    .stop_i    (state_q != ST_WAIT && !ev_sent),
    .expire_o  (tmr_exp)
  );

  // only the rising edge of bus-off is an event; the level stays while
  // the controller is off the bus and must not retrigger the auto reset.
  // warning and passive indications are deliberately not inputs at all
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      boff_prev_q <= 1'b0;
    else
      boff_prev_q <= bus_off_i;
  end

  always_comb
  begin
    boff_ev      = bus_off_i && !boff_prev_q;                       // [R13] [R14]
    in_pre       = (state_q == ST_SEND) || (state_q == ST_WAIT);
    in_on        = (state_q == ST_ONLINE);
    ev_boff_hold = boff_ev && (in_pre || (in_on && !bus_off_action_attr_i)); // [R5] [R6]
    ev_auto      = boff_ev && in_on && bus_off_action_attr_i;       // [R7]
    ev_dup       = !boff_ev && ((in_pre && (rx_req || rx_rsp)) || (in_on && rx_rsp)); // [R10]
    ev_sent      = (state_q == ST_SEND) && tx_done_i && !boff_ev && !ev_dup; // [R2]
    ev_retry     = (state_q == ST_WAIT) && tmr_exp && !tmo_seen_q && !boff_ev && !ev_dup; // [R3]
    ev_online    = (state_q == ST_WAIT) && tmr_exp && tmo_seen_q && !boff_ev && !ev_dup; // [R4]
    ev_resp      = in_on && rx_req && !boff_ev;                     // [R9]
  end

  // bus-off ranks above duplicate detection, which ranks above the timer
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      state_q <= ST_SEND;                                           // [R1]
    else
    begin
      case (state_q)
        ST_SEND:
        begin
          if (ev_boff_hold || ev_dup)
            state_q <= ST_FAULT;                                    // [R5] [R10]
          else if (ev_sent)
            state_q <= ST_WAIT;                                     // [R2]
        end
        ST_WAIT:
        begin
          if (ev_boff_hold || ev_dup)
            state_q <= ST_FAULT;                                    // [R5] [R10]
          else if (ev_retry)
            state_q <= ST_SEND;                                     // [R3]
          else if (ev_online)
            state_q <= ST_ONLINE;                                   // [R4]
        end
        ST_ONLINE:
        begin
          if (ev_boff_hold || ev_dup)
            state_q <= ST_FAULT;                                    // [R6] [R10]
          else if (ev_auto)
            state_q <= ST_SEND;                                     // [R8]
        end
        default:
          state_q <= ST_FAULT;                                      // [R11]
      endcase
    end
  end

  // consecutive expiries: a fresh sequence after auto reset starts over
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      tmo_seen_q <= 1'b0;
    else if (ev_retry)
      tmo_seen_q <= 1'b1;
    else if (ev_online || ev_auto)
      tmo_seen_q <= 1'b0;
  end

  // request after reset or auto reset waits one cycle behind the reset pulse
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pend_q <= 1'b1;                                               // [R1]
    else
      pend_q <= ev_auto;                                            // [R8]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      req_q <= 1'b0;
      rsp_q <= 1'b0;
      id_q  <= ID_RST;
    end
    else
    begin
      req_q <= pend_q || ev_retry || ev_resp;                       // [R1] [R3] [R8] [R9]
      rsp_q <= ev_resp && !pend_q && !ev_retry;
      id_q  <= nad_chk_id(node_address_i);                          // [R15]
    end
  end

  // transceiver hold only leaves via a full reset of the node
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      xcvr_q <= 1'b0;
    else if (ev_boff_hold)
      xcvr_q <= 1'b1;                                               // [R5] [R6]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      ctrl_q <= 1'b0;
    else
      ctrl_q <= ev_auto;                                            // [R7]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      dup_q <= 1'b0;
    else if (ev_dup)
      dup_q <= 1'b1;                                                // [R10]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      acc_q <= 1'b0;
      go_q  <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      acc_q <= in_on && rx_other;                                   // [R11]
      go_q  <= in_on && int_tx_req_i;                               // [R12]
      err_q <= !in_on && int_tx_req_i;                              // [R12]
    end
  end

  assign chk_tx_req_o = req_q;
  assign chk_tx_rsp_o = rsp_q;
  assign chk_tx_id_o  = id_q;
  assign xcvr_reset_o = xcvr_q;
  assign ctrl_reset_o = ctrl_q;
  assign dup_detect_o = dup_q;
  assign rx_accept_o  = acc_q;
  assign int_tx_go_o  = go_q;
  assign int_err_o    = err_q;
  assign state_o      = state_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  property p_reset_req;
    // the request is launched by the first edge after release, so it shows one cycle later
    $fell(rst_i) |-> (state_q == ST_SEND && !chk_tx_req_o) ##1 (chk_tx_req_o && !chk_tx_rsp_o);
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("no check request after reset"); // [R1]

  property p_sent_wait;
    ev_sent |=> state_q == ST_WAIT && !tmr_exp;
  endproperty
  a_sent_wait: assert property (p_sent_wait) else $error("sent request did not enter waiting"); // [R2]

  property p_retry;
    ev_retry |=> state_q == ST_SEND && chk_tx_req_o && !chk_tx_rsp_o && tmo_seen_q;
  endproperty
  a_retry: assert property (p_retry) else $error("first expiry did not resend"); // [R3]

  property p_online;
    ev_online |=> state_q == ST_ONLINE && !chk_tx_req_o;
  endproperty
  a_online: assert property (p_online) else $error("second expiry did not go on-line"); // [R4]

  property p_boff_pre;
    boff_ev && in_pre |=> state_q == ST_FAULT && xcvr_reset_o;
  endproperty
  a_boff_pre: assert property (p_boff_pre) else $error("bus-off before on-line not handled"); // [R5]

  property p_boff_hold;
    boff_ev && in_on && !bus_off_action_attr_i |=> state_q == ST_FAULT && xcvr_reset_o;
  endproperty
  a_boff_hold: assert property (p_boff_hold) else $error("bus-off hold action not taken"); // [R6]

  property p_auto;
    ev_auto |=> ctrl_reset_o && !chk_tx_req_o && state_q == ST_SEND
      ##1 chk_tx_req_o && !ctrl_reset_o && !xcvr_reset_o;
  endproperty
  a_auto: assert property (p_auto) else $error("auto reset order wrong"); // [R7] [R8]

  property p_resp;
    ev_resp |=> chk_tx_req_o && chk_tx_rsp_o && chk_tx_id_o == nad_chk_id($past(node_address_i));
  endproperty
  a_resp: assert property (p_resp) else $error("check request not answered"); // [R9] [R15]

  property p_dup;
    ev_dup |=> state_q == ST_FAULT && dup_detect_o;
  endproperty
  a_dup: assert property (p_dup) else $error("duplicate not declared"); // [R10]

  property p_accept;
    rx_accept_o |-> $past(state_q) == ST_ONLINE;
  endproperty
  a_accept: assert property (p_accept) else $error("message passed outside on-line"); // [R11]

  property p_fault_sticky;
    state_q == ST_FAULT |=> state_q == ST_FAULT && !chk_tx_req_o;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault state left or sent"); // [R11]

  property p_int_tx;
    int_tx_req_i |=> (int_tx_go_o != int_err_o) && (int_tx_go_o == ($past(state_q) == ST_ONLINE));
  endproperty
  a_int_tx: assert property (p_int_tx) else $error("internal transmit gating wrong"); // [R12]

  property p_passive_stay;
    bus_off_i && boff_prev_q && state_q != ST_FAULT && !rx_valid_i && !tx_done_i && !tmr_exp
      |=> $stable(state_q);
  endproperty
  a_passive_stay: assert property (p_passive_stay) else $error("state moved without event"); // [R14]

  c_online: cover property (ev_online);
  c_retry: cover property (ev_retry ##[1:40] ev_sent);
  c_auto: cover property (ev_auto ##2 state_q == ST_SEND);
  c_dup: cover property (ev_dup && in_on);

endmodule
`default_nettype wire

/* test/nad_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
// stands for the other nodes: acknowledges each check frame after a set delay
module nad_bus_model
  import nad_pkg::*;
(
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic            chk_tx_req_i,
  input  wire logic            chk_tx_rsp_i,
  input  wire logic [ID_W-1:0] chk_tx_id_i,
  input  wire logic [3:0]      ack_dly_i,
  input  wire logic            stall_i,
  output logic                 tx_done_o,
  output logic [ID_W-1:0]      last_id_o,
  output logic                 last_rsp_o
);
  logic [4:0] cnt_q;

  always_ff @(posedge clk_sys_i)
  begin
    tx_done_o <= 1'h0;
    if (rst_i)
    begin
      cnt_q      <= 5'h00;
      last_id_o  <= ID_RST;
      last_rsp_o <= 1'h0;
    end
    else if (chk_tx_req_i)
    begin
      cnt_q      <= {1'h0, ack_dly_i} + 5'h01;
      last_id_o  <= chk_tx_id_i;
      last_rsp_o <= chk_tx_rsp_i;
    end
    // no acknowledge: the lone sender retries, goes error passive and waits here
    else if (cnt_q != 5'h00 && !stall_i)
    begin
      cnt_q     <= cnt_q - 5'h01;
      tx_done_o <= (cnt_q == 5'h01);
    end
  end
endmodule
`default_nettype wire

/* test/nad_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, exp, got); end end
module nad_top_tb
  import nad_pkg::*;
;
  localparam int unsigned CYC = 20;
  logic              clk_sys_i;
  logic              rst_i;
  logic [ADDR_W-1:0] addr;
  logic              attr;
  logic              bus_off;
  logic              rx_valid;
  logic [ID_W-1:0]   rx_id;
  logic [7:0]        rx_d0;
  logic              int_req;
  logic [3:0]        ack_dly;
  logic              stall;
  logic              tx_done;
  logic              req_o, rsp_o, xcvr_o, crst_o, dup_o, acc_o, go_o, err_o, last_rsp;
  logic [ID_W-1:0]   id_o, last_id;
  logic [1:0]        st;
  int                num_checks = 0, miscompares = 0, cyc, r0, k;
  int                n_req = 0, n_go = 0, n_err = 0, n_acc = 0, n_crst = 0;
  integer            seed;

  nad_top #(.CHECK_CYCLES(CYC)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .node_address_i(addr), .bus_off_action_attr_i(attr), .bus_off_i(bus_off),
    .tx_done_i(tx_done), .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_data0_i(rx_d0),
    .int_tx_req_i(int_req), .chk_tx_req_o(req_o), .chk_tx_rsp_o(rsp_o), .chk_tx_id_o(id_o),
    .xcvr_reset_o(xcvr_o), .ctrl_reset_o(crst_o), .dup_detect_o(dup_o), .rx_accept_o(acc_o),
    .int_tx_go_o(go_o), .int_err_o(err_o), .state_o(st));

  nad_bus_model u_bus (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .chk_tx_req_i(req_o),
    .chk_tx_rsp_i(rsp_o), .chk_tx_id_i(id_o), .ack_dly_i(ack_dly), .stall_i(stall),
    .tx_done_o(tx_done), .last_id_o(last_id), .last_rsp_o(last_rsp));

  initial
  begin
    clk_sys_i = 1'h0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // pulse outputs are counted so scenarios compare deltas, not exact edges
  always @(posedge clk_sys_i)
  begin
    if (rst_i === 1'h0)
    begin
      if (req_o === 1'h1) n_req++;
      if (go_o === 1'h1) n_go++;
      if (err_o === 1'h1) n_err++;
      if (acc_o === 1'h1) n_acc++;
      if (crst_o === 1'h1) n_crst++;
    end
  end

  function automatic logic [ID_W-1:0] exp_id(input logic [ADDR_W-1:0] a);
    return {2'h2, a, 3'h7};
  endfunction

  // group-1 identifiers can never look like a check frame
  function automatic logic [ID_W-1:0] rand_id();
    return 11'($random(seed)) & 11'h3ff;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic do_reset(input logic stl, input logic at);
    @(posedge clk_sys_i);
    rst_i   <= 1'h1;
    bus_off <= 1'h0;
    stall   <= stl;
    attr    <= at;
    addr    <= 6'($random(seed));
    ack_dly <= 4'($random(seed));
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    tick(2);
  endtask

  task automatic pulse_rx(input logic [ID_W-1:0] id, input logic [7:0] d0);
    @(posedge clk_sys_i);
    rx_valid <= 1'h1;
    rx_id    <= id;
    rx_d0    <= d0;
    @(posedge clk_sys_i);
    rx_valid <= 1'h0;
    tick(2);
  endtask

  task automatic pulse_int();
    @(posedge clk_sys_i);
    int_req <= 1'h1;
    @(posedge clk_sys_i);
    int_req <= 1'h0;
    tick(2);
  endtask

  task automatic wait_state(input logic [1:0] s);
    cyc = 0;
    while (st !== s && cyc < 200)
    begin
      tick(1);
      cyc++;
    end
  endtask

  task automatic summarize();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    miscompares++;
    summarize();
  end

  initial
  begin
    seed = 32'h1a9a_e2ac;
    rst_i = 1'h1;
    attr = 1'h0;
    bus_off = 1'h0;
    rx_valid = 1'h0;
    rx_id = ID_RST;
    rx_d0 = 8'h00;
    int_req = 1'h0;
    ack_dly = 4'h0;
    stall = 1'h1;
    addr = 6'h00;
    do_reset(1'h1, 1'h0);
    `CHK("req_count", n_req, 1)
    `CHK("req_id", last_id, exp_id(addr))
    `CHK("req_kind", last_rsp, 1'h0)
    tick(30);
    `CHK("lone_state", st, 2'h0)
    r0 = n_err;
    pulse_int();
    `CHK("err_send", n_err, r0 + 1)
    r0 = n_acc;
    pulse_rx(rand_id(), 8'h00);
    `CHK("acc_send", n_acc, r0)
    @(posedge clk_sys_i);
    stall <= 1'h0;
    wait_state(2'h1);
    `CHK("to_wait", st, 2'h1)
    wait_state(2'h0);
    `CHK("tmr_min", cyc >= CYC * 9 / 10, 1'h1)
    `CHK("tmr_max", cyc <= CYC * 3 / 2, 1'h1)
    tick(1);
    `CHK("resend", n_req, 2)
    wait_state(2'h1);
    wait_state(2'h2);
    `CHK("online", st, 2'h2)
    r0 = n_go;
    pulse_int();
    `CHK("go_online", n_go, r0 + 1)
    r0 = n_acc;
    pulse_rx(rand_id(), 8'h00);
    `CHK("acc_online", n_acc, r0 + 1)
    r0 = n_req;
    pulse_rx(exp_id(addr ^ 6'h01), 8'h00);
    `CHK("other_addr", n_req, r0)
    pulse_rx(exp_id(addr), {1'h0, 7'($random(seed))});
    `CHK("rsp_sent", n_req, r0 + 1)
    `CHK("rsp_kind", last_rsp, 1'h1)
    `CHK("rsp_id", last_id, exp_id(addr))
    pulse_rx(exp_id(addr), 8'h80);
    `CHK("dup_online", dup_o, 1'h1)
    `CHK("fault", st, 2'h3)
    r0 = n_req;
    pulse_rx(exp_id(addr), 8'h00);
    `CHK("fault_discard", n_req, r0)
    r0 = n_err;
    pulse_int();
    `CHK("err_fault", n_err, r0 + 1)
    // even k: caught while waiting, odd k: while sending; k[1] picks response
    for (k = 0; k < 4; k++)
    begin
      do_reset(k[0], 1'h0);
      if (!k[0]) wait_state(2'h1);
      pulse_rx(exp_id(addr), {k[1], 7'($random(seed))});
      `CHK("dup_early", dup_o, 1'h1)
      `CHK("dup_state", st, 2'h3)
    end
    // bus-off in send, wait, on-line with hold, on-line with auto recovery
    for (k = 0; k < 4; k++)
    begin
      do_reset(1'h0, k[0]);
      if (k > 0) wait_state(2'h1);
      if (k > 1) wait_state(2'h2);
      r0 = n_crst;
      @(posedge clk_sys_i);
      bus_off <= 1'h1;
      tick(2);
      if (k == 3)
      begin
        `CHK("auto_state", st, 2'h0)
        `CHK("auto_ctrl", n_crst, r0 + 1)
        `CHK("auto_req", req_o, 1'h1)
        `CHK("auto_xcvr", xcvr_o, 1'h0)
      end
      else
      begin
        `CHK("hold_xcvr", xcvr_o, 1'h1)
        `CHK("hold_state", st, 2'h3)
      end
    end
    tick(5);
    summarize();
  end
endmodule
`default_nettype wire
